// *** rtl/dts_pkg.sv ***
// Package of constants and carriers for the debug trigger and status block
package dts_pkg;
    // ========================================
    // Register byte offsets
    localparam logic [3:0] DTS_OFF_CONTROL = 4'h0;
    localparam logic [3:0] DTS_OFF_TRIGGER = 4'h4;
    localparam logic [3:0] DTS_OFF_STATUS = 4'h8;
    localparam logic [3:0] DTS_OFF_FIFO_LO = 4'hC;
    // ========================================
    // Field positions
    localparam int DTS_CTL_EN = 7;
    localparam int DTS_CTL_ARM = 6;
    localparam int DTS_TRG_TAG = 7;
    localparam int DTS_TRG_BEGIN = 6;
    localparam int DTS_ST_AF = 7;
    localparam int DTS_ST_BF = 6;
    localparam int DTS_ST_ARMED_FLAG = 5;
    // Writable bits of trigger config, 4 and 5 hard-wired low
    localparam logic [7:0] DTS_TRG_MASK = 8'hCF;
    // ========================================
    // Reset values, full count and buffer depth
    localparam logic [7:0] DTS_RST_CONTROL = 8'h00;
    localparam logic [7:0] DTS_RST_TRIGGER = 8'h00;
    localparam logic [3:0] DTS_CNT_FULL = 4'h8;
    localparam int DTS_DEPTH = 8;
    // ========================================
    // Trigger modes
    localparam logic [3:0] DTS_M_A = 4'h0;
    localparam logic [3:0] DTS_M_A_OR_B = 4'h1;
    localparam logic [3:0] DTS_M_A_THEN_B = 4'h2;
    localparam logic [3:0] DTS_M_EV_B = 4'h3;
    localparam logic [3:0] DTS_M_A_EV_B = 4'h4;
    localparam logic [3:0] DTS_M_A_AND_B = 4'h5;
    localparam logic [3:0] DTS_M_A_NOT_B = 4'h6;
    localparam logic [3:0] DTS_M_INSIDE = 4'h7;
    localparam logic [3:0] DTS_M_OUTSIDE = 4'h8;
    // AXI OKAY and DECERR responses
    localparam logic [1:0] DTS_RESP_OK = 2'h0;
    localparam logic [1:0] DTS_RESP_DEC = 2'h3;
    // ========================================
    // One observed CPU bus cycle
    typedef struct packed {
        logic valid;      // Qualifying bus cycle
        logic [15:0] addr; // Access address
        logic [7:0] data; // Access data
        logic rd;         // Read cycle
        logic opfetch;    // Opcode fetch cycle
        logic opexec;     // Tracked opcode now executes
    } dts_bus_s;
endpackage

// *** rtl/dts_top.sv ***
// Trigger selection, run status and AXI4-Lite registers of the debug trace
`timescale 1ns/1ns
module dts_top (
    input wire logic clock,
    input wire logic reset,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // CPU bus observation and comparator values
    input wire dts_pkg::dts_bus_s cpu_bus,
    input wire logic [15:0] cmp_a,
    input wire logic [15:0] cmp_b,
    input wire logic secure_mode,
    // Trigger and capture outputs
    output logic trigger_pulse,
    output logic store_pulse,
    output logic armed_flag
);
    import dts_pkg::*;

    // ========================================
    // Registers
    logic [7:0] debug_control_reg_ff; // Enable and arm
    logic [7:0] trigger_config_ff;    // Trigger configuration
    logic match_a_flag_ff;            // Comparator A seen
    logic match_b_flag_ff;            // Comparator B seen
    logic [3:0] valid_word_count_ff;  // Words at run end
    logic [3:0] fill_ff;              // Words stored this run
    logic seq_a_ff;                   // A seen, for sequence modes
    logic storing_ff;                 // Begin trace started
    logic tag_a_ff;                   // Tagged A pending execution
    logic tag_b_ff;                   // Tagged B pending execution
    logic [2:0] rd_ptr_ff;            // FIFO read pointer
    logic secure_s1_ff;               // Synchroniser stage 1
    logic secure_s2_ff;               // Synchroniser stage 2
    logic trigger_pulse_ff;
    logic store_pulse_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [3:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // ========================================
    // Decode helpers
    function automatic logic mode_event_only(input logic [3:0] m);
        mode_event_only = (m == DTS_M_EV_B) || (m == DTS_M_A_EV_B);
    endfunction

    function automatic logic addr_mapped(input logic [3:0] a);
        addr_mapped = (a == DTS_OFF_CONTROL) || (a == DTS_OFF_TRIGGER) ||
                      (a == DTS_OFF_STATUS) || (a == DTS_OFF_FIFO_LO);
    endfunction

    // ========================================
    // Secure level is asynchronous; two stages before use
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            secure_s1_ff <= 1'b0;
            secure_s2_ff <= 1'b0;
        end else begin
            secure_s1_ff <= secure_mode;
            secure_s2_ff <= secure_s1_ff;
        end
    end

    // ========================================
    // Comparators
    logic [3:0] mode;
    logic en;
    logic armed;
    logic hit_a;
    logic hit_b;
    logic data_b;
    assign mode = trigger_config_ff[3:0];
    assign en = debug_control_reg_ff[DTS_CTL_EN];
    assign armed = en && debug_control_reg_ff[DTS_CTL_ARM];
    assign hit_a = cpu_bus.valid && (cpu_bus.addr == cmp_a);
    assign hit_b = cpu_bus.valid && (cpu_bus.addr == cmp_b);
    assign data_b = cpu_bus.valid && (cpu_bus.data == cmp_b[7:0]);

    // Raw matches per mode, before tag qualification
    logic raw_a;
    logic raw_b;
    always_comb begin
        raw_a = 1'b0;
        raw_b = 1'b0;
        case (mode)
            DTS_M_A: raw_a = hit_a;
            DTS_M_A_OR_B, DTS_M_A_THEN_B, DTS_M_EV_B, DTS_M_A_EV_B: begin
                raw_a = hit_a;
                raw_b = hit_b;
            end
            DTS_M_A_AND_B: begin
                raw_a = hit_a;
                raw_b = hit_a && data_b;
            end
            DTS_M_A_NOT_B: begin
                raw_a = hit_a;
                raw_b = hit_a && !data_b;
            end
            DTS_M_INSIDE: begin
                raw_a = cpu_bus.valid && (cpu_bus.addr >= cmp_a) &&
                        (cpu_bus.addr <= cmp_b);
                raw_b = raw_a;
            end
            DTS_M_OUTSIDE: begin
                raw_a = cpu_bus.valid && ((cpu_bus.addr < cmp_a) ||
                        (cpu_bus.addr > cmp_b));
                raw_b = raw_a;
            end
            default: begin
                // Codes 9 to 15 never trigger
                raw_a = 1'b0;
                raw_b = 1'b0;
            end
        endcase
    end

    // Tag qualification: a match waits for its opcode to execute
    logic tag;
    logic m_a;
    logic m_b;
    assign tag = trigger_config_ff[DTS_TRG_TAG];
    assign m_a = tag ? (tag_a_ff && cpu_bus.opexec) : raw_a;
    assign m_b = tag ? (tag_b_ff && cpu_bus.opexec) : raw_b;

    // Tracks tagged opcode fetches until execution
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tag_a_ff <= 1'b0;
            tag_b_ff <= 1'b0;
        end else if (!armed || cpu_bus.opexec) begin
            tag_a_ff <= 1'b0;
            tag_b_ff <= 1'b0;
        end else if (cpu_bus.opfetch) begin
            tag_a_ff <= raw_a;
            tag_b_ff <= raw_b;
        end
    end

    // Trigger and store decisions
    logic fire;
    logic store_ev;
    logic is_begin;
    assign is_begin = trigger_config_ff[DTS_TRG_BEGIN] ||
                      mode_event_only(mode);
    always_comb begin
        fire = 1'b0;
        store_ev = 1'b0;
        case (mode)
            DTS_M_A: fire = m_a;
            DTS_M_A_OR_B: fire = m_a || m_b;
            DTS_M_A_THEN_B: fire = seq_a_ff && m_b;
            DTS_M_EV_B: store_ev = m_b;
            DTS_M_A_EV_B: store_ev = seq_a_ff && m_b;
            DTS_M_A_AND_B, DTS_M_A_NOT_B: fire = m_b;
            DTS_M_INSIDE, DTS_M_OUTSIDE: fire = m_a;
            default: fire = 1'b0;
        endcase
        // Begin trace stores each qualifying cycle once started
        if (!mode_event_only(mode) && (storing_ff || fire) && is_begin) begin
            store_ev = cpu_bus.valid;
        end
        if (!is_begin) begin
            store_ev = cpu_bus.valid; // End trace stores each qualifying cycle until fill reaches eight
        end
        fire = fire && armed;
        store_ev = store_ev && armed;
    end

    logic [3:0] fill_nxt;
    logic run_done;
    assign fill_nxt = (store_ev && fill_ff != DTS_CNT_FULL) ?
                      fill_ff + 4'h1 : fill_ff;
    // Full in begin trace, trigger in end trace
    assign run_done = armed && (is_begin ? (fill_nxt == DTS_CNT_FULL) :
                                           fire);

    // ========================================
    // Register bus write path
    logic wr_go;
    logic [7:0] wbyte;
    logic rd_go;
    assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wbyte = w_strb_ff[0] ? w_data_ff[7:0] : 8'h00;
    assign rd_go = s_axi_arvalid && s_axi_arready;

    logic wr_ctl;
    logic arm_start;
    assign wr_ctl = wr_go && (aw_addr_ff == DTS_OFF_CONTROL) && w_strb_ff[0];
    assign arm_start = wr_ctl && wbyte[DTS_CTL_ARM] && wbyte[DTS_CTL_EN] &&
                       !(secure_s2_ff && !en) && !armed;

    // Control register: enable and arm
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            debug_control_reg_ff <= DTS_RST_CONTROL;
        end else if (wr_ctl) begin
            debug_control_reg_ff <= wbyte;
            if (secure_s2_ff && !en) begin
                debug_control_reg_ff[DTS_CTL_EN] <= 1'b0;
                debug_control_reg_ff[DTS_CTL_ARM] <= 1'b0;
            end
            if (!wbyte[DTS_CTL_EN]) begin
                debug_control_reg_ff[DTS_CTL_ARM] <= 1'b0;
            end
        end else if (run_done) begin
            debug_control_reg_ff[DTS_CTL_ARM] <= 1'b0;
        end
    end

    // Trigger configuration accepts writes only when unarmed
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            trigger_config_ff <= DTS_RST_TRIGGER;
        end else if (wr_go && aw_addr_ff == DTS_OFF_TRIGGER &&
                     w_strb_ff[0] && !debug_control_reg_ff[DTS_CTL_ARM]) begin
            trigger_config_ff <= wbyte & DTS_TRG_MASK;
        end
    end

    // ========================================
    // Run state: flags, sequence, fill and count
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            match_a_flag_ff <= 1'b0;
            match_b_flag_ff <= 1'b0;
            seq_a_ff <= 1'b0;
            storing_ff <= 1'b0;
            fill_ff <= 4'h0;
            valid_word_count_ff <= 4'h0;
        end else if (arm_start) begin
            match_a_flag_ff <= 1'b0;
            match_b_flag_ff <= 1'b0;
            seq_a_ff <= 1'b0;
            storing_ff <= 1'b0;
            fill_ff <= 4'h0;
            valid_word_count_ff <= 4'h0;
        end else if (armed) begin
            if (m_a) begin
                match_a_flag_ff <= 1'b1;
                seq_a_ff <= 1'b1;
            end
            if (m_b) begin
                match_b_flag_ff <= 1'b1;
            end
            if (fire) begin
                storing_ff <= 1'b1;
            end
            fill_ff <= fill_nxt;
            // Count latched as words stored; stays after the run
            valid_word_count_ff <= fill_nxt;
        end
    end

    // FIFO read pointer: low byte read advances when not armed
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rd_ptr_ff <= 3'h0;
        end else if (arm_start) begin
            rd_ptr_ff <= 3'h0;
        end else if (rd_go && s_axi_araddr == DTS_OFF_FIFO_LO && !armed) begin
            rd_ptr_ff <= rd_ptr_ff + 3'h1;
        end
    end

    // Pulse outputs
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            trigger_pulse_ff <= 1'b0;
            store_pulse_ff <= 1'b0;
        end else begin
            trigger_pulse_ff <= fire;
            store_pulse_ff <= store_ev && (fill_ff != DTS_CNT_FULL);
        end
    end

    // ========================================
    // AXI write channel capture, either order
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= 4'h0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= DTS_RESP_OK;
        end else begin
            if (s_axi_awvalid && !aw_held_ff) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_ff) begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                // Status and FIFO are read-only; writes ignored
                bvalid_ff <= 1'b1;
                bresp_ff <= addr_mapped(aw_addr_ff) ? DTS_RESP_OK :
                            DTS_RESP_DEC;
            end
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
            end
        end
    end

    // AXI read channel
    logic [7:0] status_byte;
    assign status_byte = {match_a_flag_ff, match_b_flag_ff, armed, 1'b0,
                          valid_word_count_ff};
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= DTS_RESP_OK;
        end else if (rd_go) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= addr_mapped(s_axi_araddr) ? DTS_RESP_OK : DTS_RESP_DEC;
            case (s_axi_araddr)
                DTS_OFF_CONTROL: rdata_ff <= {24'h000000, debug_control_reg_ff};
                DTS_OFF_TRIGGER: rdata_ff <= {24'h000000, trigger_config_ff};
                DTS_OFF_STATUS: rdata_ff <= {24'h000000, status_byte};
                DTS_OFF_FIFO_LO: rdata_ff <= {29'h00000000, rd_ptr_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Ready terms from flip-flops only
    assign s_axi_awready = !aw_held_ff;
    assign s_axi_wready = !w_held_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign trigger_pulse = trigger_pulse_ff;
    assign store_pulse = store_pulse_ff;
    assign armed_flag = debug_control_reg_ff[DTS_CTL_ARM];

    // ========================================
    // Assertions
    sequence s_cfg_write_armed;
        wr_go && aw_addr_ff == DTS_OFF_TRIGGER && w_strb_ff[0] &&
        debug_control_reg_ff[DTS_CTL_ARM];
    endsequence

    AST_CFG_LOCKED: assert property (@(posedge clock) disable iff (reset)
        s_cfg_write_armed |=> $stable(trigger_config_ff))
        else $error("trigger config changed while armed");
    AST_CFG_ZERO: assert property (@(posedge clock) disable iff (reset)
        trigger_config_ff[5:4] == 2'h0)
        else $error("trigger config bits 5:4 not zero");
    AST_NO_TRIG_HIGH: assert property (@(posedge clock) disable iff (reset)
        mode > DTS_M_OUTSIDE |-> !fire && !run_done)
        else $error("reserved mode produced a trigger");
    AST_START_CLEARS: assert property (@(posedge clock) disable iff (reset)
        arm_start |=> valid_word_count_ff == 4'h0 && !match_a_flag_ff)
        else $error("run start did not clear status");
    AST_END_TRACE_STOP: assert property (@(posedge clock) disable iff (reset)
        armed && !is_begin && fire && !wr_ctl |=> !armed_flag)
        else $error("end trace trigger did not disarm");
    AST_DISABLE_STOP: assert property (@(posedge clock) disable iff (reset)
        wr_ctl && !wbyte[DTS_CTL_EN] |=> !armed_flag)
        else $error("disable did not stop the run");
    AST_COUNT_HOLD: assert property (@(posedge clock) disable iff (reset)
        !armed && !arm_start |=> $stable(valid_word_count_ff))
        else $error("count changed outside a run");
    AST_SECURE_EN: assert property (@(posedge clock) disable iff (reset)
        secure_s2_ff && !en |=> !en)
        else $error("enable set while secure");
endmodule

// *** testbench/dts_host.sv ***
// Host model: AXI4-Lite master that reads trace results
`timescale 1ns/1ns
module dts_host
    import dts_pkg::*;
(
    input wire logic clock,
    output logic [3:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [3:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // Words the host still expects to pull from the trace buffer
    int words_left = 0;
    // ========================================
    // Idle master at time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h000;
        s_axi_wdata = 32'h0;
    end
    // ========================================
    // Write: offer address and data together, release each when taken
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // Response only after both halves are taken
        s_axi_bready <= 1'b1;
        do @(posedge clock); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    // ========================================
    // Read; a low-byte trace read uses up one word of the host's count
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        if (a == DTS_OFF_FIFO_LO && words_left > 0) begin
            words_left--;
        end
    endtask
endmodule

// *** testbench/dts_top_tb.sv ***
// Self-checking bench for the debug trigger and status block
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module dts_top_tb;
    import dts_pkg::*;
    logic clock, reset, secure_mode;
    logic [3:0] awaddr, wstrb, araddr;
    logic [31:0] wdata, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    dts_bus_s cpu_bus;
    logic [15:0] cmp_a, cmp_b;
    logic trigger_pulse, store_pulse, armed_flag;
    int n_mismatch = 0, checks = 0, cycles = 0, n_trig = 0, n_store = 0;
    int t0;
    // Modes that one access sequence below should fire
    localparam logic [15:0] FIRE = 16'h01E7;
    // ========================================
    // Clock, reset and quiet inputs
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        reset = 1'b1;
        secure_mode = 1'b0;
        cpu_bus = '0;
        cmp_a = 16'h1000;
        cmp_b = 16'h2000;
    end
    dts_top DUT (.clock(clock), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cpu_bus(cpu_bus), .cmp_a(cmp_a),
        .cmp_b(cmp_b), .secure_mode(secure_mode),
        .trigger_pulse(trigger_pulse), .store_pulse(store_pulse),
        .armed_flag(armed_flag));
    dts_host host (.clock(clock), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    // ========================================
    // Pulse counters and hang guard; a run needs well under 10k cycles
    always @(posedge clock) begin
        cycles++;
        if (trigger_pulse === 1'b1) n_trig++;
        if (store_pulse === 1'b1) n_store++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // ========================================
    // Shared tasks
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task hw(input logic [3:0] a, input logic [7:0] d);
        host.wr(a, {24'h0, d});
    endtask
    // Upper 24 bits always compared: byte registers read zero above
    task rd_chk(input logic [3:0] a, input logic [7:0] m,
                input logic [7:0] e, input string n);
        logic [31:0] d;
        host.rd(a, d);
        `CHK(n, {24'h0, e}, d & {24'hFFFFFF, m})
    endtask
    // One qualifying CPU bus cycle, then an idle one
    task bus(input logic [15:0] a, input logic [7:0] d, input logic f,
             input logic e);
        @(posedge clock);
        cpu_bus <= '{1'b1, a, d, 1'b0, f, e};
        @(posedge clock);
        cpu_bus <= '0;
    endtask
    task settle;
        repeat (4) @(posedge clock);
    endtask
    // Arm with a fresh trigger setup; a new run starts with clean status
    task arm(input logic [7:0] cfg);
        hw(DTS_OFF_TRIGGER, cfg);
        hw(DTS_OFF_CONTROL, 8'hC0);
        rd_chk(DTS_OFF_STATUS, 8'hFF, 8'h20, "status_armed");
        t0 = n_trig;
    endtask
    // ========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        rd_chk(DTS_OFF_CONTROL, 8'hFF, DTS_RST_CONTROL, "ctl_rst");
        rd_chk(DTS_OFF_TRIGGER, 8'hFF, DTS_RST_TRIGGER, "trg_rst");
        rd_chk(DTS_OFF_STATUS, 8'hFF, 8'h00, "sts_rst");
        hw(DTS_OFF_TRIGGER, 8'hFF);
        rd_chk(DTS_OFF_TRIGGER, 8'hFF, DTS_TRG_MASK, "trg_fixed");
        hw(DTS_OFF_STATUS, 8'hFF);
        `CHK("sts_wr_resp", DTS_RESP_OK, bresp)
        rd_chk(DTS_OFF_STATUS, 8'hFF, 8'h00, "sts_ro");
        // Every trigger mode except 3 and 4, force type, end trace
        for (int m = 0; m < 16; m++) begin
            if (m == 3 || m == 4) continue;
            arm({4'h0, 4'(m)});
            `CHK("armed_pin", 1'b1, armed_flag)
            if (m == 0) begin
                hw(DTS_OFF_TRIGGER, 8'h05);
                rd_chk(DTS_OFF_TRIGGER, 8'hFF, 8'h00, "trg_locked");
                `CHK("trg_rd_resp", DTS_RESP_OK, rresp)
            end
            case (4'(m))
                DTS_M_A_OR_B: bus(16'h2000, 8'h00, 1'b0, 1'b0);
                DTS_M_A_THEN_B: begin
                    bus(16'h2000, 8'h00, 1'b0, 1'b0);
                    bus(16'h1000, 8'h00, 1'b0, 1'b0);
                    bus(16'h2000, 8'h00, 1'b0, 1'b0);
                end
                DTS_M_A_NOT_B: bus(16'h1000, 8'h55, 1'b0, 1'b0);
                DTS_M_OUTSIDE: bus(16'h0FFF, 8'h00, 1'b0, 1'b0);
                default: bus(16'h1000, 8'h00, 1'b0, 1'b0);
            endcase
            settle();
            `CHK("fired", FIRE[m], 1'(n_trig != t0))
            `CHK("run_end", ~FIRE[m], armed_flag)
            if (m == 0) begin
                rd_chk(DTS_OFF_STATUS, 8'hE0, 8'h80, "a_flag");
            end
            hw(DTS_OFF_CONTROL, 8'h00);
            `CHK("stopped", 1'b0, armed_flag)
        end
        // Host stops a run by dropping only the enable bit
        arm(8'h09);
        hw(DTS_OFF_CONTROL, 8'h40);
        rd_chk(DTS_OFF_STATUS, 8'h20, 8'h00, "en_stop");
        // Tag type: fetch alone is silent, execution fires
        arm(8'h80);
        bus(16'h1000, 8'h00, 1'b1, 1'b0);
        settle();
        `CHK("tag_fetch", 1'b0, 1'(n_trig != t0))
        bus(16'h1000, 8'h00, 1'b0, 1'b1);
        settle();
        `CHK("tag_exec", 1'b1, 1'(n_trig != t0))
        // Event-only B with end select still fills eight words
        arm({4'h0, DTS_M_EV_B});
        t0 = n_store;
        for (int i = 0; i < 8; i++) bus(16'h2000, 8'(i), 1'b0, 1'b0);
        settle();
        `CHK("ev_stores", 8, n_store - t0)
        rd_chk(DTS_OFF_STATUS, 8'h6F, 8'h48, "ev_full");
        host.words_left = 8;
        // Each low-byte read moves the read pointer on by one
        for (int i = 0; i < 3; i++) begin
            rd_chk(DTS_OFF_FIFO_LO, 8'h07, 8'(i), "fifo_rd");
        end
        rd_chk(DTS_OFF_STATUS, 8'h0F, DTS_CNT_FULL, "cnt_hold");
        `CHK("host_left", 5, host.words_left)
        // A then each B: B before A stores nothing
        arm({4'h0, DTS_M_A_EV_B});
        t0 = n_store;
        bus(16'h2000, 8'h00, 1'b0, 1'b0);
        bus(16'h1000, 8'h00, 1'b0, 1'b0);
        bus(16'h2000, 8'h00, 1'b0, 1'b0);
        settle();
        `CHK("a_ev_b", 1, n_store - t0)
        hw(DTS_OFF_CONTROL, 8'h00);
        // Begin trace: trigger starts capture, full buffer ends run
        arm(8'h40);
        bus(16'h1000, 8'h00, 1'b1, 1'b0);
        settle();
        `CHK("begin_armed", 1'b1, armed_flag)
        for (int i = 0; i < 12; i++) bus(16'h3000 + 16'(i), 8'h00, 1'b1, 1'b0);
        settle();
        rd_chk(DTS_OFF_STATUS, 8'h2F, 8'h08, "begin_full");
        // Secure mode blocks setting the enable bit; drop it first
        hw(DTS_OFF_CONTROL, 8'h00);
        secure_mode <= 1'b1;
        settle();
        hw(DTS_OFF_CONTROL, 8'hC0);
        rd_chk(DTS_OFF_CONTROL, 8'h80, 8'h00, "secure_en");
        `CHK("secure_arm", 1'b0, armed_flag)
        tally_and_finish();
    end
endmodule
